/* include/ckg_pkg.sv */
// Shared constants and types for the clock generator and master clock block.
package ckg_pkg;

	// Register port widths.
	localparam int CKG_ADDR_W = 8;
	localparam int CKG_DATA_W = 32;

	// Register byte offsets, one aligned word each.
	localparam logic [7:0] CKG_OFS_SC_ENABLE = 8'h00;
	localparam logic [7:0] CKG_OFS_SC_DISABLE = 8'h04;
	localparam logic [7:0] CKG_OFS_SC_STATUS = 8'h08;
	localparam logic [7:0] CKG_OFS_OSC_CTRL = 8'h20;
	localparam logic [7:0] CKG_OFS_FREQ_COUNT = 8'h24;
	localparam logic [7:0] CKG_OFS_PLL_SETUP = 8'h2C;
	localparam logic [7:0] CKG_OFS_MASTER_CLK = 8'h30;
	localparam logic [7:0] CKG_OFS_POWER_STATUS = 8'h68;
	localparam logic [7:0] CKG_OFS_IRQ_MASK = 8'h6C;

	// Field widths.
	localparam int CKG_STARTUP_W = 8;
	localparam int CKG_SETTLE_W = 6;
	localparam int CKG_DIV_W = 8;
	localparam int CKG_MUL_W = 11;
	localparam int CKG_FREQ_W = 16;
	localparam int CKG_MASTER_CLOCK_RATIO_W = 3;
	localparam int CKG_CNT_W = 8;

	// Oscillator control register fields.
	localparam int CKG_MOR_EN_BIT = 0;
	localparam int CKG_MOR_SKIP_BIT = 1;
	localparam int CKG_MOR_CNT_LSB = 8;

	// Frequency count register fields.
	localparam int CKG_MCFR_DONE_BIT = 16;

	// PLL setup register fields.
	localparam int CKG_PLLR_DIV_LSB = 0;
	localparam int CKG_PLLR_CNT_LSB = 8;
	localparam int CKG_PLLR_OUT_LSB = 14;
	localparam int CKG_PLLR_MUL_LSB = 16;
	localparam int CKG_PLLR_USB_LSB = 28;

	// Master clock register fields.
	localparam int CKG_MCKR_CSS_LSB = 0;
	localparam int CKG_MCKR_MASTER_CLOCK_RATIO_LSB = 2;

	// Status, mask and system clock bit positions.
	localparam int CKG_SR_MOSC_BIT = 0;
	localparam int CKG_SR_LOCK_BIT = 2;
	localparam int CKG_SR_MASTER_CLOCK_READY_BIT = 3;
	localparam int CKG_SC_PCK_BIT = 0;
	localparam int CKG_SC_USB_BIT = 7;

	// Clock source select encodings.
	localparam logic [1:0] CKG_SRC_SLOW = 2'h0;
	localparam logic [1:0] CKG_SRC_MAIN = 2'h1;
	localparam logic [1:0] CKG_SRC_PLL = 2'h3;

	// Reset values.
	localparam logic [1:0] CKG_RST_CSS = 2'h0;
	localparam logic [2:0] CKG_RST_MASTER_CLOCK_RATIO = 3'h0;
	localparam logic [7:0] CKG_RST_DIV = 8'h00;
	localparam logic [10:0] CKG_RST_MUL = 11'h000;
	localparam logic [2:0] CKG_RST_IRQ_MASK = 3'h0;

	// Cycle counts.
	localparam logic [2:0] CKG_SLOW_DIV8_LAST = 3'h7;
	localparam logic [3:0] CKG_FREQ_LAST_FALL = 4'hF;
	localparam logic [1:0] CKG_MCK_SETTLE_EDGES = 2'h2;

	// Frequency counter states.
	typedef enum logic [1:0] {CKG_FC_IDLE, CKG_FC_ARM, CKG_FC_RUN, CKG_FC_DONE} ckg_fc_state_t;

endpackage

/* include/ckg_cnt_if.sv */
`timescale 1ns/1ps
// Control and status of one slow-clock down-counter.
interface ckg_cnt_if;
	logic load;
	logic abort;
	logic tick;
	logic [7:0] value;
	logic done;

	// The owner loads and ticks; the counter reports expiry.
	modport ctl (output load, output abort, output tick, output value, input done);
	modport cnt (input load, input abort, input tick, input value, output done);
endinterface

/* rtl/ckg_down_counter.sv */
`timescale 1ns/1ps
// Loadable down-counter that raises a sticky done level when it runs out.
module ckg_down_counter
	import ckg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	ckg_cnt_if.cnt cif
);

	logic [CKG_CNT_W-1:0] cnt_q; // Remaining ticks.
	logic busy_q; // Counting in progress.
	logic done_q; // Counter has expired.

	// A load restarts the count; a load of zero expires at once.
	// Abort wins over everything so that a disabled source never reports ready.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= 8'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else if (cif.abort)
		begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else if (cif.load)
		begin
			cnt_q <= cif.value;
			busy_q <= (cif.value != 8'h00);
			done_q <= (cif.value == 8'h00);
		end
		else if (busy_q && cif.tick)
		begin
			// The tick that takes the count from one to zero ends the wait.
			cnt_q <= cnt_q - 8'h01;
			if (cnt_q == 8'h01)
			begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
			end
		end
	end

	assign cif.done = done_q;

endmodule

/* rtl/ckg_clock_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// - Slow clock times start-up, frequency count and settle; master ready counts source edges.
// - Reset: oscillator off, slow clock selected.
// - Clearing oscillator enable clears stable flag.
// - Enable write restarts start-up count, slow/8.
// - Start-up count field is eight bits.
// - Count at zero sets stable, may interrupt.
// - Frequency count starts after next slow rise.
// - Sixteenth slow fall stops count, sets done.
// - Input divide accepts one to 255.
// - Divide zero holds PLL output low.
// - PLL output is source times (gain+1)/divide.
// - Gain zero powers PLL down.
// - PLL re-enable or change clears settled flag.
// - Settle counter on slow clock sets settled.
// - Master clock is source over power of two.
// - Master clock write clears ready until established.
// - Processor clock on at reset, woken by interrupts.
// - Processor clock stops after current instruction.
// - Enable/disable writes switch processor clock; status readable.
// - USB clock switched by enable/disable after settle.
// - Reset master clock equals slow clock.
// - Unsettled PLL source falls back to main clock.
module ckg_clock_ctrl
	import ckg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [CKG_ADDR_W-1:0] reg_addr,
	input wire logic [CKG_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [CKG_DATA_W-1:0] reg_rdata_q,
	input wire logic slow_clk_pin,
	input wire logic main_clk_pin,
	input wire logic pll_clk_pin,
	input wire logic instr_done,
	input wire logic wake_irq,
	output logic main_osc_enable_q,
	output logic crystal_skip_q,
	output logic pll_power_q,
	output logic [CKG_DIV_W-1:0] pll_input_ratio_q,
	output logic [CKG_MUL_W-1:0] pll_gain_factor_q,
	output logic [1:0] pll_range_q,
	output logic pll_clock_q,
	output logic master_clock_q,
	output logic master_clock_ready_q,
	output logic processor_clock_en_q,
	output logic usb_device_clock_q,
	output logic irq_q
);

	// True when a strobe hits the given register word.
	function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
		hit = strobe && (addr == ofs);
	endfunction

	// Synchronisers for the three clock pins: slow, main and PLL in that order.
	logic [2:0] pins;
	logic [2:0] pin_meta_q; // First stage, read only by the second stage.
	logic [2:0] pin_sync_q; // Second stage, safe for logic.
	logic [2:0] pin_prev_q; // Delayed copy for edge detection.
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;

	assign pins = {pll_clk_pin, main_clk_pin, slow_clk_pin};

	// Each pin gets the same two-stage synchroniser and edge detector.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge clk_sys or negedge arst_n)
			begin
				if (!arst_n)
				begin
					pin_meta_q[gi] <= 1'b0;
					pin_sync_q[gi] <= 1'b0;
					pin_prev_q[gi] <= 1'b0;
				end
				else
				begin
					pin_meta_q[gi] <= pins[gi];
					pin_sync_q[gi] <= pin_meta_q[gi];
					pin_prev_q[gi] <= pin_sync_q[gi];
				end
			end
			assign pin_rise[gi] = pin_sync_q[gi] && !pin_prev_q[gi];
			assign pin_fall[gi] = !pin_sync_q[gi] && pin_prev_q[gi];
		end
	endgenerate

	// Named views of the synchronised clocks.
	logic slow_rise;
	logic slow_fall;
	logic main_lvl;
	logic main_rise;
	assign slow_rise = pin_rise[0];
	assign slow_fall = pin_fall[0];
	assign main_lvl = pin_sync_q[1];
	assign main_rise = pin_rise[1];

	// Register strobes.
	logic wr_mor;
	logic wr_pllr;
	logic wr_mckr;
	logic wr_scer;
	logic wr_scdr;
	logic wr_imr;
	assign wr_mor = hit(reg_wr, reg_addr, CKG_OFS_OSC_CTRL);
	assign wr_pllr = hit(reg_wr, reg_addr, CKG_OFS_PLL_SETUP);
	assign wr_mckr = hit(reg_wr, reg_addr, CKG_OFS_MASTER_CLK);
	assign wr_scer = hit(reg_wr, reg_addr, CKG_OFS_SC_ENABLE);
	assign wr_scdr = hit(reg_wr, reg_addr, CKG_OFS_SC_DISABLE);
	assign wr_imr = hit(reg_wr, reg_addr, CKG_OFS_IRQ_MASK);

	// Oscillator control register; the oscillator starts disabled.
	logic [CKG_STARTUP_W-1:0] startup_delay_count_q;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			main_osc_enable_q <= 1'b0;
			crystal_skip_q <= 1'b0;
			startup_delay_count_q <= 8'h00;
		end
		else if (wr_mor)
		begin
			main_osc_enable_q <= reg_wdata[CKG_MOR_EN_BIT];
			// With an external clock software also clears the enable.
			crystal_skip_q <= reg_wdata[CKG_MOR_SKIP_BIT];
			startup_delay_count_q <= reg_wdata[CKG_MOR_CNT_LSB +: CKG_STARTUP_W];
		end
	end

	// The start-up counter ticks once every eight slow clock periods.
	logic [2:0] slow_div8_q;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			slow_div8_q <= 3'h0;
		else if (slow_rise)
			slow_div8_q <= slow_div8_q + 3'h1;
	end

	// Start-up counter: a write with the enable set restarts it.
	ckg_cnt_if osc_cif ();
	assign osc_cif.load = wr_mor && reg_wdata[CKG_MOR_EN_BIT];
	assign osc_cif.abort = wr_mor && !reg_wdata[CKG_MOR_EN_BIT];
	assign osc_cif.tick = slow_rise && (slow_div8_q == CKG_SLOW_DIV8_LAST);
	assign osc_cif.value = reg_wdata[CKG_MOR_CNT_LSB +: CKG_STARTUP_W];

	ckg_down_counter u_osc_cnt (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.cif(osc_cif)
	);

	// The expired counter is the stable flag; it drops on abort or a non-zero load.
	logic main_osc_stable;
	assign main_osc_stable = osc_cif.done;

	// Frequency counter. Main clock edges are seen through the 100 MHz sampler,
	// so a main clock above about half of that rate would undercount.
	ckg_fc_state_t fc_state_q;
	logic [CKG_FREQ_W-1:0] crystal_cycle_count_q;
	logic [3:0] fc_fall_q; // Slow falling edges seen so far.
	logic frequency_count_done_q;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fc_state_q <= CKG_FC_IDLE;
			crystal_cycle_count_q <= 16'h0000;
			fc_fall_q <= 4'h0;
			frequency_count_done_q <= 1'b0;
		end
		else if (!main_osc_stable)
		begin
			// Oscillator off or restarting: wait for it to become stable again.
			fc_state_q <= CKG_FC_IDLE;
			frequency_count_done_q <= 1'b0;
		end
		else
		begin
			case (fc_state_q)
				CKG_FC_IDLE:
					fc_state_q <= CKG_FC_ARM;
				CKG_FC_ARM:
				begin
					// Counting begins at the next rising slow edge.
					if (slow_rise)
					begin
						fc_state_q <= CKG_FC_RUN;
						crystal_cycle_count_q <= 16'h0000;
						fc_fall_q <= 4'h0;
					end
				end
				CKG_FC_RUN:
				begin
					if (main_rise && crystal_cycle_count_q != 16'hFFFF)
						crystal_cycle_count_q <= crystal_cycle_count_q + 16'h0001;
					if (slow_fall)
					begin
						fc_fall_q <= fc_fall_q + 4'h1;
						if (fc_fall_q == CKG_FREQ_LAST_FALL)
						begin
							fc_state_q <= CKG_FC_DONE;
							frequency_count_done_q <= 1'b1;
						end
					end
				end
				CKG_FC_DONE:
					fc_state_q <= CKG_FC_DONE;
				default:
					fc_state_q <= CKG_FC_IDLE;
			endcase
		end
	end

	// PLL setup register. Divide 1..255 is taken as written; zero stops it.
	logic [CKG_SETTLE_W-1:0] pll_settle_count_q;
	logic [1:0] usb_clock_ratio_q;
	logic pll_restart;
	assign pll_restart = wr_pllr && (reg_wdata[CKG_PLLR_MUL_LSB +: CKG_MUL_W] != 11'h000)
		&& ((reg_wdata[CKG_PLLR_DIV_LSB +: CKG_DIV_W] != pll_input_ratio_q)
		|| (reg_wdata[CKG_PLLR_MUL_LSB +: CKG_MUL_W] != pll_gain_factor_q) || !pll_power_q);
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pll_input_ratio_q <= CKG_RST_DIV;
			pll_gain_factor_q <= CKG_RST_MUL;
			pll_settle_count_q <= 6'h00;
			pll_range_q <= 2'h0;
			usb_clock_ratio_q <= 2'h0;
			pll_power_q <= 1'b0;
		end
		else if (wr_pllr)
		begin
			pll_input_ratio_q <= reg_wdata[CKG_PLLR_DIV_LSB +: CKG_DIV_W];
			pll_gain_factor_q <= reg_wdata[CKG_PLLR_MUL_LSB +: CKG_MUL_W];
			pll_settle_count_q <= reg_wdata[CKG_PLLR_CNT_LSB +: CKG_SETTLE_W];
			pll_range_q <= reg_wdata[CKG_PLLR_OUT_LSB +: 2];
			usb_clock_ratio_q <= reg_wdata[CKG_PLLR_USB_LSB +: 2];
			// The analog loop is powered only with a non-zero gain.
			pll_power_q <= (reg_wdata[CKG_PLLR_MUL_LSB +: CKG_MUL_W] != 11'h000);
		end
	end

	// Settle counter decrements once per slow clock period.
	ckg_cnt_if pll_cif ();
	assign pll_cif.load = pll_restart;
	assign pll_cif.abort = wr_pllr && (reg_wdata[CKG_PLLR_MUL_LSB +: CKG_MUL_W] == 11'h000);
	assign pll_cif.tick = slow_rise;
	assign pll_cif.value = {2'h0, reg_wdata[CKG_PLLR_CNT_LSB +: CKG_SETTLE_W]};

	ckg_down_counter u_pll_cnt (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.cif(pll_cif)
	);

	logic pll_settled;
	assign pll_settled = pll_cif.done;

	// PLL clock path: held low while divide or gain is zero.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			pll_clock_q <= 1'b0;
		else
			pll_clock_q <= pin_sync_q[2] && (pll_input_ratio_q != 8'h00) && pll_power_q;
	end

	// Delayed PLL level for edge detection. The synchroniser's own delayed copy
	// runs in step with pll_clock_q, so it could never show a rise.
	logic pll_prev_q;
	logic pll_rise;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			pll_prev_q <= 1'b0;
		else
			pll_prev_q <= pll_clock_q;
	end
	assign pll_rise = pll_clock_q && !pll_prev_q;

	// Master clock register.
	logic [1:0] clock_source_select_q;
	logic [CKG_MASTER_CLOCK_RATIO_W-1:0] master_clock_ratio_q;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			clock_source_select_q <= CKG_RST_CSS;
			master_clock_ratio_q <= CKG_RST_MASTER_CLOCK_RATIO;
		end
		else if (wr_mckr)
		begin
			clock_source_select_q <= reg_wdata[CKG_MCKR_CSS_LSB +: 2];
			master_clock_ratio_q <= reg_wdata[CKG_MCKR_MASTER_CLOCK_RATIO_LSB +: CKG_MASTER_CLOCK_RATIO_W];
		end
	end

	// Effective source: an unsettled PLL is replaced by the main clock.
	logic pll_fallback;
	logic [1:0] eff_src;
	logic src_lvl;
	logic src_rise;
	assign pll_fallback = (clock_source_select_q == CKG_SRC_PLL) && !pll_settled;
	assign eff_src = pll_fallback ? CKG_SRC_MAIN : clock_source_select_q;
	always_comb
	begin
		case (eff_src)
			CKG_SRC_MAIN:
			begin
				src_lvl = main_lvl;
				src_rise = main_rise;
			end
			CKG_SRC_PLL:
			begin
				src_lvl = pll_clock_q;
				src_rise = pll_rise;
			end
			default:
			begin
				src_lvl = pin_sync_q[0];
				src_rise = slow_rise;
			end
		endcase
	end

	// Prescaler: bit n-1 of an edge counter divides the source by 2^n.
	logic [5:0] master_clock_ratio_cnt_q;
	logic [2:0] master_clock_ratio_bit;
	assign master_clock_ratio_bit = master_clock_ratio_q - 3'h1;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			master_clock_ratio_cnt_q <= 6'h00;
			master_clock_q <= 1'b0;
		end
		else
		begin
			if (src_rise)
				master_clock_ratio_cnt_q <= master_clock_ratio_cnt_q + 6'h01;
			// Ratio 0 passes the source through; 1..6 divide by 2 to 64.
			if (master_clock_ratio_q == 3'h0 || master_clock_ratio_q == 3'h7)
				master_clock_q <= src_lvl;
			else
				master_clock_q <= master_clock_ratio_cnt_q[master_clock_ratio_bit];
		end
	end

	// Ready flag: a write starts a wait of two source edges for the new clock.
	logic [1:0] mck_wait_q;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mck_wait_q <= 2'h0;
			master_clock_ready_q <= 1'b1;
		end
		else if (wr_mckr)
		begin
			mck_wait_q <= CKG_MCK_SETTLE_EDGES;
			master_clock_ready_q <= 1'b0;
		end
		else if (pll_fallback)
			master_clock_ready_q <= 1'b0;
		else if (mck_wait_q != 2'h0)
		begin
			if (src_rise)
				mck_wait_q <= mck_wait_q - 2'h1;
		end
		else
			master_clock_ready_q <= 1'b1;
	end

	// Processor clock: a disable waits for the instruction boundary.
	// A wake-up wins over a pending or fresh disable so that no interrupt is lost.
	logic pck_stop_pend_q;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			processor_clock_en_q <= 1'b1;
			pck_stop_pend_q <= 1'b0;
		end
		else if (wake_irq || (wr_scer && reg_wdata[CKG_SC_PCK_BIT]))
		begin
			processor_clock_en_q <= 1'b1;
			pck_stop_pend_q <= 1'b0;
		end
		else if (wr_scdr && reg_wdata[CKG_SC_PCK_BIT])
			pck_stop_pend_q <= processor_clock_en_q;
		else if (pck_stop_pend_q && instr_done)
		begin
			processor_clock_en_q <= 1'b0;
			pck_stop_pend_q <= 1'b0;
		end
	end

	// USB clock enable, honoured only once the PLL has settled.
	logic usb_en_q;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			usb_en_q <= 1'b0;
		else if (wr_scdr && reg_wdata[CKG_SC_USB_BIT])
			usb_en_q <= 1'b0;
		else if (wr_scer && reg_wdata[CKG_SC_USB_BIT] && pll_settled)
			usb_en_q <= 1'b1;
	end

	// USB clock: the PLL clock divided by 1, 2 or 4.
	logic [1:0] usb_div_q;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			usb_div_q <= 2'h0;
			usb_device_clock_q <= 1'b0;
		end
		else
		begin
			if (pll_rise)
				usb_div_q <= usb_div_q + 2'h1;
			if (!usb_en_q)
				usb_device_clock_q <= 1'b0;
			else if (usb_clock_ratio_q == 2'h0)
				usb_device_clock_q <= pll_clock_q;
			else if (usb_clock_ratio_q == 2'h1)
				usb_device_clock_q <= usb_div_q[0];
			else
				usb_device_clock_q <= usb_div_q[1];
		end
	end

	// Interrupt mask and combined level request.
	logic [2:0] irq_mask_q;
	logic [2:0] status_flags;
	assign status_flags = {master_clock_ready_q, pll_settled, main_osc_stable};
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq_mask_q <= CKG_RST_IRQ_MASK;
			irq_q <= 1'b0;
		end
		else
		begin
			if (wr_imr)
				irq_mask_q <= {reg_wdata[CKG_SR_MASTER_CLOCK_READY_BIT], reg_wdata[CKG_SR_LOCK_BIT], reg_wdata[CKG_SR_MOSC_BIT]};
			irq_q <= |(status_flags & irq_mask_q);
		end
	end

	// Read data stand for one cycle after the read strobe, zero otherwise.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata_q <= 32'h00000000;
		else
		begin
			reg_rdata_q <= 32'h00000000;
			if (hit(reg_rd, reg_addr, CKG_OFS_OSC_CTRL))
			begin
				reg_rdata_q[CKG_MOR_EN_BIT] <= main_osc_enable_q;
				reg_rdata_q[CKG_MOR_SKIP_BIT] <= crystal_skip_q;
				reg_rdata_q[CKG_MOR_CNT_LSB +: CKG_STARTUP_W] <= startup_delay_count_q;
			end
			else if (hit(reg_rd, reg_addr, CKG_OFS_FREQ_COUNT))
			begin
				reg_rdata_q[CKG_FREQ_W-1:0] <= crystal_cycle_count_q;
				reg_rdata_q[CKG_MCFR_DONE_BIT] <= frequency_count_done_q;
			end
			else if (hit(reg_rd, reg_addr, CKG_OFS_PLL_SETUP))
			begin
				reg_rdata_q[CKG_PLLR_DIV_LSB +: CKG_DIV_W] <= pll_input_ratio_q;
				reg_rdata_q[CKG_PLLR_CNT_LSB +: CKG_SETTLE_W] <= pll_settle_count_q;
				reg_rdata_q[CKG_PLLR_OUT_LSB +: 2] <= pll_range_q;
				reg_rdata_q[CKG_PLLR_MUL_LSB +: CKG_MUL_W] <= pll_gain_factor_q;
				reg_rdata_q[CKG_PLLR_USB_LSB +: 2] <= usb_clock_ratio_q;
			end
			else if (hit(reg_rd, reg_addr, CKG_OFS_MASTER_CLK))
			begin
				reg_rdata_q[CKG_MCKR_CSS_LSB +: 2] <= clock_source_select_q;
				reg_rdata_q[CKG_MCKR_MASTER_CLOCK_RATIO_LSB +: CKG_MASTER_CLOCK_RATIO_W] <= master_clock_ratio_q;
			end
			else if (hit(reg_rd, reg_addr, CKG_OFS_SC_STATUS))
			begin
				reg_rdata_q[CKG_SC_PCK_BIT] <= processor_clock_en_q;
				reg_rdata_q[CKG_SC_USB_BIT] <= usb_en_q;
			end
			else if (hit(reg_rd, reg_addr, CKG_OFS_POWER_STATUS))
			begin
				reg_rdata_q[CKG_SR_MOSC_BIT] <= main_osc_stable;
				reg_rdata_q[CKG_SR_LOCK_BIT] <= pll_settled;
				reg_rdata_q[CKG_SR_MASTER_CLOCK_READY_BIT] <= master_clock_ready_q;
			end
			else if (hit(reg_rd, reg_addr, CKG_OFS_IRQ_MASK))
			begin
				reg_rdata_q[CKG_SR_MOSC_BIT] <= irq_mask_q[0];
				reg_rdata_q[CKG_SR_LOCK_BIT] <= irq_mask_q[1];
				reg_rdata_q[CKG_SR_MASTER_CLOCK_READY_BIT] <= irq_mask_q[2];
			end
		end
	end

endmodule

/* verif/ckg_clock_ctrl_asserts.sv */
`timescale 1ns/1ps
// Port-level checks of the clock controller; it sees only the top pins.
module ckg_clock_ctrl_asserts
	import ckg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [CKG_ADDR_W-1:0] reg_addr,
	input wire logic [CKG_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic instr_done,
	input wire logic wake_irq,
	input wire logic main_osc_enable_q,
	input wire logic pll_power_q,
	input wire logic [CKG_DIV_W-1:0] pll_input_ratio_q,
	input wire logic [CKG_MUL_W-1:0] pll_gain_factor_q,
	input wire logic pll_clock_q,
	input wire logic master_clock_ready_q,
	input wire logic processor_clock_en_q
);
	// One clock domain, so clocking and reset are given once.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_mck_wr_clears: assert property (reg_wr && reg_addr == CKG_OFS_MASTER_CLK |=> !master_clock_ready_q)
		else $error("ready not cleared by master clock write");
	// Two cycles of zero divide rule out a lag of the synced clock.
	a_pll_zero_low: assert property (pll_input_ratio_q == 8'h00 ##1 pll_input_ratio_q == 8'h00 |-> !pll_clock_q)
		else $error("pll clock moves with zero divide");
	a_pll_power_gain: assert property ($stable(pll_gain_factor_q) |-> pll_power_q == (pll_gain_factor_q != 11'h000))
		else $error("pll power disagrees with gain");
	a_pck_hold_on: assert property (processor_clock_en_q && !instr_done |=> processor_clock_en_q)
		else $error("processor clock stopped mid instruction");
	a_pck_wake: assert property (wake_irq |=> processor_clock_en_q)
		else $error("processor clock not woken");
	a_pck_enable: assert property (reg_wr && reg_addr == CKG_OFS_SC_ENABLE && reg_wdata[0] |=> processor_clock_en_q)
		else $error("processor clock enable write lost");
	a_osc_en_write: assert property (reg_wr && reg_addr == CKG_OFS_OSC_CTRL |=> main_osc_enable_q == $past(reg_wdata[0]))
		else $error("oscillator enable not taken");
	a_pll_fields: assert property (reg_wr && reg_addr == CKG_OFS_PLL_SETUP |=>
		pll_input_ratio_q == $past(reg_wdata[7:0]) && pll_gain_factor_q == $past(reg_wdata[26:16]))
		else $error("pll divide or gain not taken");
endmodule

bind ckg_clock_ctrl ckg_clock_ctrl_asserts u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .instr_done(instr_done), .wake_irq(wake_irq),
	.main_osc_enable_q(main_osc_enable_q), .pll_power_q(pll_power_q), .pll_input_ratio_q(pll_input_ratio_q),
	.pll_gain_factor_q(pll_gain_factor_q), .pll_clock_q(pll_clock_q),
	.master_clock_ready_q(master_clock_ready_q), .processor_clock_en_q(processor_clock_en_q));

/* verif/tb_ckg_clock_ctrl.sv */
`timescale 1ns/1ps
// Register-level test of the clock controller with synthetic pin clocks.
module tb_ckg_clock_ctrl
	import ckg_pkg::*;
;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic slow_clk_pin = 1'b0;
	logic main_clk_pin = 1'b0;
	logic pll_clk_pin = 1'b0;
	logic instr_done = 1'b0;
	logic wake_irq = 1'b0;
	logic [31:0] reg_rdata_q, rdat;
	logic osc_en, skip, pll_power_q, pll_clock_q, master_clock, master_clock_ready_q, pck_en, usb_ck, irq_q;
	logic [7:0] ratio;
	logic [10:0] gain;
	logic [1:0] range;
	logic [7:0] cyc = 8'h00;
	int err_count = 0;
	int samples_checked = 0;
	int n;

	always #5 clk_sys = ~clk_sys;

	// Pin clocks: slow is clk/16, main clk/4, pll clk/8; slow must be far below main.
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 8'h01;
		slow_clk_pin <= cyc[3];
		main_clk_pin <= cyc[1];
		pll_clk_pin <= cyc[2];
	end

	ckg_clock_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .slow_clk_pin(slow_clk_pin),
		.main_clk_pin(main_clk_pin), .pll_clk_pin(pll_clk_pin), .instr_done(instr_done), .wake_irq(wake_irq),
		.main_osc_enable_q(osc_en), .crystal_skip_q(skip), .pll_power_q(pll_power_q), .pll_input_ratio_q(ratio),
		.pll_gain_factor_q(gain), .pll_range_q(range), .pll_clock_q(pll_clock_q), .master_clock_q(master_clock),
		.master_clock_ready_q(master_clock_ready_q), .processor_clock_en_q(pck_en),
		.usb_device_clock_q(usb_ck), .irq_q(irq_q));

	task report_and_stop;
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			$display("Error at %0t: got %h expected %h", $time, g, e);
			err_count++;
		end
	endtask

	task chk1(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask

	// A write strobe lasts one cycle; the leading edge wait keeps strobes apart.
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the read edge.
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_q;
	endtask

	task chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a, rdat);
		chk(rdat & m, e);
	endtask

	// Polls one bit with a cycle bound; returns the cycles spent.
	task poll(input logic [7:0] a, input int b, input int lim, output int c);
		c = 0;
		do
		begin
			rd(a, rdat);
			c += 2;
		end while (rdat[b] !== 1'b1 && c < lim);
		chk1(rdat[b], 1'b1);
	endtask

	// Counts rising edges of the master clock (sel 0) or USB clock (sel 1) over k cycles.
	task wait_chk(input int k, input logic g_sel, input int e);
		logic p, v;
		int r;
		r = 0;
		p = g_sel ? usb_ck : master_clock;
		repeat (k)
		begin
			@(posedge clk_sys);
			#1 v = g_sel ? usb_ck : master_clock;
			if (v && !p)
				r++;
			p = v;
		end
		chk(r, e);
	endtask

	initial
	begin
		repeat (30000) @(posedge clk_sys);
		err_count++;
		report_and_stop;
	end

	initial
	begin
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		wait_chk(32, 1'b0, 2);
		chk_rd(CKG_OFS_SC_STATUS, 32'h81, 32'h01);
		chk_rd(CKG_OFS_OSC_CTRL, 32'hFFFFFFFF, 32'h0);
		chk_rd(CKG_OFS_MASTER_CLK, 32'hFFFFFFFF, 32'h0);
		chk_rd(CKG_OFS_PLL_SETUP, 32'hFFFFFFFF, 32'h0);
		chk_rd(8'hFC, 32'hFFFFFFFF, 32'h0);
		wr(CKG_OFS_OSC_CTRL, 32'h0201);
		chk_rd(CKG_OFS_POWER_STATUS, 32'h1, 32'h0);
		poll(CKG_OFS_POWER_STATUS, 0, 500, n);
		chk1(n >= 130 && n <= 400, 1'b1);
		wr(CKG_OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk_sys);
		#1 chk1(irq_q, 1'b1);
		wr(CKG_OFS_IRQ_MASK, 32'h0);
		poll(CKG_OFS_FREQ_COUNT, 16, 400, n);
		chk1(rdat[15:0] >= 16'h003E && rdat[15:0] <= 16'h0042, 1'b1);
		wr(CKG_OFS_MASTER_CLK, 32'h05);
		chk_rd(CKG_OFS_POWER_STATUS, 32'h8, 32'h0);
		poll(CKG_OFS_POWER_STATUS, 3, 100, n);
		wait_chk(32, 1'b0, 4);
		wr(CKG_OFS_OSC_CTRL, 32'h2);
		#1 chk1(skip, 1'b1);
		chk_rd(CKG_OFS_POWER_STATUS, 32'h1, 32'h0);
		wr(CKG_OFS_PLL_SETUP, 32'h00043F01);
		chk_rd(CKG_OFS_POWER_STATUS, 32'h4, 32'h0);
		wr(CKG_OFS_SC_ENABLE, 32'h80);
		chk_rd(CKG_OFS_SC_STATUS, 32'h80, 32'h0);
		wr(CKG_OFS_MASTER_CLK, 32'h07);
		repeat (40) @(posedge clk_sys);
		#1 chk1(master_clock_ready_q, 1'b0);
		poll(CKG_OFS_POWER_STATUS, 2, 1400, n);
		poll(CKG_OFS_POWER_STATUS, 3, 200, n);
		wait_chk(32, 1'b0, 2);
		wr(CKG_OFS_SC_ENABLE, 32'h80);
		chk_rd(CKG_OFS_SC_STATUS, 32'h80, 32'h80);
		wait_chk(32, 1'b1, 4);
		wr(CKG_OFS_SC_DISABLE, 32'h80);
		chk_rd(CKG_OFS_SC_STATUS, 32'h80, 32'h0);
		wait_chk(16, 1'b1, 0);
		wr(CKG_OFS_PLL_SETUP, 32'h00048302);
		poll(CKG_OFS_POWER_STATUS, 2, 200, n);
		chk1(n >= 20 && n <= 80, 1'b1);
		chk_rd(CKG_OFS_PLL_SETUP, 32'hFFFFFFFF, 32'h00048302);
		chk({30'h0, range}, 32'h2);
		wr(CKG_OFS_PLL_SETUP, 32'h00000302);
		#1 chk1(pll_power_q, 1'b0);
		chk_rd(CKG_OFS_POWER_STATUS, 32'h4, 32'h0);
		wr(CKG_OFS_PLL_SETUP, 32'h00040000);
		repeat (20) @(posedge clk_sys);
		#1 chk1(pll_clock_q, 1'b0);
		wr(CKG_OFS_SC_DISABLE, 32'h1);
		repeat (4) @(posedge clk_sys);
		#1 chk1(pck_en, 1'b1);
		@(posedge clk_sys);
		instr_done <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 chk1(pck_en, 1'b0);
		chk_rd(CKG_OFS_SC_STATUS, 32'h1, 32'h0);
		@(posedge clk_sys);
		wake_irq <= 1'b1;
		@(posedge clk_sys);
		wake_irq <= 1'b0;
		#1 chk1(pck_en, 1'b1);
		wr(CKG_OFS_SC_DISABLE, 32'h1);
		repeat (3) @(posedge clk_sys);
		wr(CKG_OFS_SC_ENABLE, 32'h1);
		#1 chk1(pck_en, 1'b1);
		report_and_stop;
	end
endmodule
